//--- rtl/ir_timer_defs.svh
// register map, field positions and reset values of the infrared timer
`ifndef IR_TIMER_DEFS_SVH
`define IR_TIMER_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IRT_ADDR_W        3
`define IRT_OFF_CTRL      3'h0
`define IRT_OFF_CARRIER   3'h1
`define IRT_OFF_MODTIME   3'h2
`define IRT_OFF_VALUE     3'h3
`define IRT_OFF_STATUS    3'h4
`define IRT_OFF_MASK      3'h5
`define IRT_OFF_POWER     3'h6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define IRT_CTRL_EN       0
`define IRT_CTRL_MODE     1
`define IRT_CTRL_DATA     2
`define IRT_CTRL_POL      3
`define IRT_CTRL_CFME     4
`define IRT_CTRL_SEL_LO   5
`define IRT_CTRL_SEL_HI   6
`define IRT_CTRL_RELOAD   7
`define IRT_CTRL_BURST    8
`define IRT_CTRL_DIV_LO   9
`define IRT_CTRL_DIV_HI   10

// ----------------------------------------------------------------
// status, mask and power-control fields
// ----------------------------------------------------------------
`define IRT_ST_OVF        0
`define IRT_ST_CAP        1
`define IRT_PWR_LEVEL     0
`define IRT_PWR_OE        1

// ----------------------------------------------------------------
// edge-select encodings
// ----------------------------------------------------------------
`define IRT_SEL_FALL      2'h0
`define IRT_SEL_RISE      2'h1

// ----------------------------------------------------------------
// reset values and counter maximum
// ----------------------------------------------------------------
`define IRT_RST_WORD16    16'h0000
`define IRT_RST_BYTE      8'h00
`define IRT_MAX16         16'hFFFF

`endif

//--- rtl/ir_timer_pkg.sv
// types shared by the infrared timer
package ir_timer_pkg;

  typedef enum logic [1:0] {
    ST_OFF      = 2'b00,
    ST_TX       = 2'b01,
    ST_RX_WAIT  = 2'b10,
    ST_RX_COUNT = 2'b11
  } ir_state_e;

endpackage

//--- rtl/ir_carrier_modulation_timer.sv
// infrared carrier generator, modulator and receive capture timer
`timescale 1ns/1ns
`include "ir_timer_defs.svh"

module ir_carrier_modulation_timer #(
  parameter int DIV_W = 2
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_resetn,
  input  wire logic [`IRT_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [15:0]            o_rdata,
  input  wire logic                   i_infrared_receive_pin,
  output logic                        o_ir_tx_out,
  output logic                        o_ir_tx_oe_n,
  output logic                        o_irq
);
  import ir_timer_pkg::*;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic             infrared_timer_enable_reg;
  logic             transmit_receive_select_reg;
  logic             ir_data_bit_reg;
  logic             transmit_polarity_reg;
  logic             counter_clock_select_reg;
  logic [1:0]       capture_edge_select_reg;
  logic             capture_reload_enable_reg;
  logic             burst_count_enable_reg;
  logic [DIV_W-1:0] ir_clock_divider_reg;
  logic [15:0]      ir_carrier_times_reg;
  logic [15:0]      modulator_time_register_reg;
  logic [15:0]      ir_counter_value_reg;
  logic [1:0]       status_reg;
  logic [1:0]       mask_reg;
  logic [1:0]       power_control_register_reg;
  logic [15:0]      rdata_reg;

  // ----------------------------------------------------------------
  // engine state
  // ----------------------------------------------------------------
  ir_state_e        state_reg;
  ir_state_e        state_next;
  logic [7:0]       prescale_reg;
  logic [7:0]       phase_cnt_reg;
  logic             phase_high_reg;
  logic [15:0]      carrier_lat_reg;
  logic             pol_lat_reg;
  logic             data_lat_reg;
  logic             rx_prev_reg;
  logic             tx_out_reg;
  logic             tx_oe_n_reg;

  logic             infrared_prescaled_clock;
  logic             carrier_end;
  logic             count_tick;
  logic             rise;
  logic             fall;
  logic             qualified;
  logic             tx_reload;
  logic             capture;
  logic             ovf_event;
  logic             wr_ctrl;
  logic             tx_level;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // prescaled clock tick: every 2^div system clocks
  function automatic logic div_tick(input logic [7:0] cnt, input logic [DIV_W-1:0] div);
    logic [7:0] lowmask;
    lowmask = 8'((9'h001 << div) - 9'h001);
    return (cnt & lowmask) == lowmask;
  endfunction

  // edge qualification per edge-select field
  function automatic logic edge_ok(input logic [1:0] sel, input logic r, input logic f);
    logic ok;
    ok = r | f;
    if (sel == `IRT_SEL_FALL) begin
      ok = f;
    end else if (sel == `IRT_SEL_RISE) begin
      ok = r;
    end
    return ok;
  endfunction

  assign wr_ctrl = i_wr && (i_addr == `IRT_OFF_CTRL);

  // ----------------------------------------------------------------
  // prescaler and carrier generator
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale_reg <= `IRT_RST_BYTE;
    end else if (!infrared_timer_enable_reg || tx_reload) begin
      // restart on each interval so its first carrier phase is full length
      prescale_reg <= `IRT_RST_BYTE;
    end else begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  assign infrared_prescaled_clock = div_tick(prescale_reg, ir_clock_divider_reg);
  assign carrier_end = infrared_prescaled_clock && !phase_high_reg && (phase_cnt_reg == `IRT_RST_BYTE);
  assign count_tick  = counter_clock_select_reg ? infrared_prescaled_clock : carrier_end;

  // each phase lasts its byte plus one prescaled clocks
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_cnt_reg  <= `IRT_RST_BYTE;
      phase_high_reg <= 1'b1;
    end else if (state_reg == ST_OFF || tx_reload) begin
      phase_cnt_reg  <= tx_reload ? ir_carrier_times_reg[15:8] : `IRT_RST_BYTE;
      phase_high_reg <= 1'b1;
    end else if (infrared_prescaled_clock) begin
      if (phase_cnt_reg != `IRT_RST_BYTE) begin
        phase_cnt_reg <= phase_cnt_reg - 8'h01;
      end else if (phase_high_reg) begin
        phase_cnt_reg  <= carrier_lat_reg[7:0];
        phase_high_reg <= 1'b0;
      end else begin
        phase_cnt_reg  <= carrier_lat_reg[15:8];
        phase_high_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  assign rise      = i_infrared_receive_pin && !rx_prev_reg;
  assign fall      = !i_infrared_receive_pin && rx_prev_reg;
  assign qualified = edge_ok(capture_edge_select_reg, rise, fall);
  assign tx_reload = (state_reg != ST_TX && state_next == ST_TX) ||
                     (state_reg == ST_TX && count_tick && ir_counter_value_reg == `IRT_RST_WORD16);
  assign capture   = (state_reg == ST_RX_COUNT) && !transmit_receive_select_reg && qualified &&
                     !burst_count_enable_reg;
  assign ovf_event = (state_reg == ST_RX_COUNT) && !transmit_receive_select_reg &&
                     !(capture && capture_reload_enable_reg) && count_tick &&
                     !burst_count_enable_reg && ir_counter_value_reg == `IRT_MAX16;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (infrared_timer_enable_reg) begin
          state_next = transmit_receive_select_reg ? ST_TX : ST_RX_WAIT;
        end
      end
      ST_TX: begin
        if (!transmit_receive_select_reg) begin
          state_next = ST_RX_WAIT;
        end
      end
      ST_RX_WAIT: begin
        if (transmit_receive_select_reg) begin
          state_next = ST_TX;
        end else if (qualified) begin
          state_next = ST_RX_COUNT;
        end
      end
      ST_RX_COUNT: begin
        if (transmit_receive_select_reg) begin
          state_next = ST_TX;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (!infrared_timer_enable_reg) begin
      state_next = ST_OFF;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg   <= ST_OFF;
      rx_prev_reg <= 1'b1;
    end else begin
      state_reg   <= (state_reg == ST_TX && state_next == ST_RX_WAIT) ? ST_OFF : state_next;
      rx_prev_reg <= i_infrared_receive_pin;
    end
  end

  // interval latch of carrier timing, polarity and data
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      carrier_lat_reg <= `IRT_RST_WORD16;
      pol_lat_reg     <= 1'b0;
      data_lat_reg    <= 1'b0;
    end else if (tx_reload) begin
      carrier_lat_reg <= ir_carrier_times_reg;
      pol_lat_reg     <= transmit_polarity_reg;
      data_lat_reg    <= ir_data_bit_reg;
    end else if (state_reg != ST_TX) begin
      carrier_lat_reg <= ir_carrier_times_reg;
      pol_lat_reg     <= transmit_polarity_reg;
    end
  end

  // ----------------------------------------------------------------
  // value counter, modulator time and data bit
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_counter_value_reg <= `IRT_RST_WORD16;
    end else if (tx_reload) begin
      ir_counter_value_reg <= modulator_time_register_reg;
    end else if (state_reg == ST_TX && count_tick) begin
      ir_counter_value_reg <= ir_counter_value_reg - 16'h0001;
    end else if (state_reg == ST_RX_WAIT && qualified) begin
      ir_counter_value_reg <= `IRT_RST_WORD16;
    end else if (capture && capture_reload_enable_reg) begin
      ir_counter_value_reg <= `IRT_RST_WORD16;
    end else if (state_reg == ST_RX_COUNT && burst_count_enable_reg && qualified) begin
      ir_counter_value_reg <= ir_counter_value_reg + 16'h0001;
    end else if (state_reg == ST_RX_COUNT && !burst_count_enable_reg && count_tick) begin
      ir_counter_value_reg <= ir_counter_value_reg + 16'h0001;
    end else if (i_wr && i_addr == `IRT_OFF_VALUE) begin
      ir_counter_value_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      modulator_time_register_reg <= `IRT_RST_WORD16;
    end else if (capture) begin
      modulator_time_register_reg <= ir_counter_value_reg;
    end else if (i_wr && i_addr == `IRT_OFF_MODTIME) begin
      modulator_time_register_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_data_bit_reg <= 1'b0;
    end else if (capture) begin
      ir_data_bit_reg <= i_infrared_receive_pin;
    end else if (wr_ctrl) begin
      ir_data_bit_reg <= i_wdata[`IRT_CTRL_DATA];
    end
  end

  // ----------------------------------------------------------------
  // control, carrier and power registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      infrared_timer_enable_reg   <= 1'b0;
      transmit_receive_select_reg <= 1'b0;
      transmit_polarity_reg       <= 1'b0;
      counter_clock_select_reg    <= 1'b0;
      capture_edge_select_reg     <= 2'h0;
      capture_reload_enable_reg   <= 1'b0;
      burst_count_enable_reg      <= 1'b0;
      ir_clock_divider_reg        <= '0;
    end else if (wr_ctrl) begin
      infrared_timer_enable_reg   <= i_wdata[`IRT_CTRL_EN];
      transmit_receive_select_reg <= i_wdata[`IRT_CTRL_MODE];
      transmit_polarity_reg       <= i_wdata[`IRT_CTRL_POL];
      counter_clock_select_reg    <= i_wdata[`IRT_CTRL_CFME];
      capture_edge_select_reg     <= i_wdata[`IRT_CTRL_SEL_HI:`IRT_CTRL_SEL_LO];
      capture_reload_enable_reg   <= i_wdata[`IRT_CTRL_RELOAD];
      burst_count_enable_reg      <= i_wdata[`IRT_CTRL_BURST];
      ir_clock_divider_reg        <= DIV_W'(i_wdata[`IRT_CTRL_DIV_HI:`IRT_CTRL_DIV_LO]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_carrier_times_reg       <= `IRT_RST_WORD16;
      power_control_register_reg <= 2'h0;
      mask_reg                   <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == `IRT_OFF_CARRIER) begin
        ir_carrier_times_reg <= i_wdata;
      end
      if (i_addr == `IRT_OFF_POWER) begin
        power_control_register_reg <= i_wdata[1:0];
      end
      if (i_addr == `IRT_OFF_MASK) begin
        mask_reg <= i_wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  // a zero written clears a flag; a new event in that cycle wins
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg <= 2'h0;
    end else begin
      status_reg[`IRT_ST_OVF] <= ovf_event ||
        (status_reg[`IRT_ST_OVF] && !(i_wr && i_addr == `IRT_OFF_STATUS && !i_wdata[`IRT_ST_OVF]));
      status_reg[`IRT_ST_CAP] <= capture ||
        (status_reg[`IRT_ST_CAP] && !(i_wr && i_addr == `IRT_OFF_STATUS && !i_wdata[`IRT_ST_CAP]));
    end
  end

  assign o_irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // transmit pin
  // ----------------------------------------------------------------
  assign tx_level = data_lat_reg ? (phase_high_reg ^ pol_lat_reg) : pol_lat_reg;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_out_reg  <= 1'b0;
      tx_oe_n_reg <= 1'b1;
    end else if (!infrared_timer_enable_reg) begin
      tx_out_reg  <= power_control_register_reg[`IRT_PWR_LEVEL];
      tx_oe_n_reg <= !power_control_register_reg[`IRT_PWR_OE];
    end else begin
      tx_out_reg  <= (state_reg == ST_TX) ? tx_level : transmit_polarity_reg;
      tx_oe_n_reg <= 1'b0;
    end
  end

  assign o_ir_tx_out  = tx_out_reg;
  assign o_ir_tx_oe_n = tx_oe_n_reg;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= `IRT_RST_WORD16;
    end else if (i_rd) begin
      case (i_addr)
        `IRT_OFF_CTRL:    rdata_reg <= {5'h00, 2'(ir_clock_divider_reg), burst_count_enable_reg,
                                        capture_reload_enable_reg, capture_edge_select_reg,
                                        counter_clock_select_reg, transmit_polarity_reg, ir_data_bit_reg,
                                        transmit_receive_select_reg, infrared_timer_enable_reg};
        `IRT_OFF_CARRIER: rdata_reg <= ir_carrier_times_reg;
        `IRT_OFF_MODTIME: rdata_reg <= modulator_time_register_reg;
        `IRT_OFF_VALUE:   rdata_reg <= ir_counter_value_reg;
        `IRT_OFF_STATUS:  rdata_reg <= {14'h0000, status_reg};
        `IRT_OFF_MASK:    rdata_reg <= {14'h0000, mask_reg};
        `IRT_OFF_POWER:   rdata_reg <= {14'h0000, power_control_register_reg};
        default:          rdata_reg <= `IRT_RST_WORD16;
      endcase
    end else begin
      rdata_reg <= `IRT_RST_WORD16;
    end
  end

  assign o_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  AST_DISABLED_PIN: assert property (
    !infrared_timer_enable_reg |=> o_ir_tx_out == $past(power_control_register_reg[`IRT_PWR_LEVEL]) &&
                                   o_ir_tx_oe_n == !$past(power_control_register_reg[`IRT_PWR_OE]))
    else $error("disabled pin does not follow power control bits");
  AST_STOP_OFF: assert property (
    !infrared_timer_enable_reg ##1 !infrared_timer_enable_reg |-> state_reg == ST_OFF)
    else $error("timer runs while disabled");
  AST_TX_LOAD: assert property (
    tx_reload |=> ir_counter_value_reg == $past(modulator_time_register_reg))
    else $error("interval did not load modulator time");
  AST_RELOAD_ZERO: assert property (
    capture && capture_reload_enable_reg |=> ir_counter_value_reg == `IRT_RST_WORD16)
    else $error("capture reload did not clear counter");
  AST_OVF_FLAG: assert property (
    ovf_event |=> status_reg[`IRT_ST_OVF] && ir_counter_value_reg == `IRT_RST_WORD16 &&
                  (o_irq || !mask_reg[`IRT_ST_OVF]))
    else $error("rollover did not set overflow");
  AST_DIV_ONE: assert property (
    infrared_timer_enable_reg && ir_clock_divider_reg == '0 |-> infrared_prescaled_clock)
    else $error("undivided prescaled clock missing");
  AST_CAPTURE: assert property (
    capture |=> modulator_time_register_reg == $past(ir_counter_value_reg) &&
                ir_data_bit_reg == $past(i_infrared_receive_pin) && state_reg != ST_RX_WAIT)
    else $error("capture did not store value and pin level");
  AST_FIRST_EVENT: assert property (
    state_reg == ST_RX_WAIT && qualified && infrared_timer_enable_reg && !transmit_receive_select_reg |=>
      state_reg == ST_RX_COUNT && ir_counter_value_reg == `IRT_RST_WORD16)
    else $error("first event did not start counting from zero");
  AST_IDLE_LEVEL: assert property (
    state_reg == ST_TX && !data_lat_reg && infrared_timer_enable_reg |=> o_ir_tx_out == $past(pol_lat_reg))
    else $error("idle interval not at polarity level");
  AST_OVF_HOLD: assert property (
    status_reg[`IRT_ST_OVF] && !(i_wr && i_addr == `IRT_OFF_STATUS) |=> status_reg[`IRT_ST_OVF])
    else $error("overflow flag dropped without a clear");

  COV_TX_INTERVAL: cover property (state_reg == ST_TX && tx_reload);
  COV_CAPTURE:     cover property (capture && capture_reload_enable_reg);
  COV_OVERFLOW:    cover property (ovf_event ##1 o_irq);

endmodule

//--- sim/ir_link_partner.sv
// infrared receiver and led driver model at the far side of the timer
`timescale 1ns/1ns

module ir_link_partner (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_light,
  input  wire logic i_tx_out,
  input  wire logic i_tx_oe_n,
  output logic      o_rx_pin,
  output logic      o_led_level
);
  // ----------------------------------------------------------------
  // receiver output: idles high through the pull-up during reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_pin <= 1'b1;
    end else begin
      o_rx_pin <= i_light;
    end
  end

  // released transmit pin is pulled up
  assign o_led_level = i_tx_oe_n ? 1'b1 : i_tx_out;
endmodule

//--- sim/test_ir_carrier_modulation_timer.sv
// self-checking bench of the infrared timer
`timescale 1ns/1ns
`include "ir_timer_defs.svh"

module test_ir_carrier_modulation_timer;
  import ir_timer_pkg::*;
  logic                   i_mclk = 1'b0;
  logic                   i_resetn = 1'b0;
  logic [`IRT_ADDR_W-1:0] i_addr = '0;
  logic [15:0]            i_wdata = '0;
  logic                   i_wr = 1'b0;
  logic                   i_rd = 1'b0;
  logic                   light = 1'b0;
  logic                   rx_pin;
  logic                   led_level;
  logic [15:0]            o_rdata;
  logic                   o_ir_tx_out;
  logic                   o_ir_tx_oe_n;
  logic                   o_irq;
  int                     n_errors = 0;
  int                     n_checks = 0;

  always #10 i_mclk = ~i_mclk;

  ir_carrier_modulation_timer dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_infrared_receive_pin(rx_pin), .o_ir_tx_out(o_ir_tx_out),
    .o_ir_tx_oe_n(o_ir_tx_oe_n), .o_irq(o_irq));
  ir_link_partner partner (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_light(light), .i_tx_out(o_ir_tx_out),
    .i_tx_oe_n(o_ir_tx_oe_n), .o_rx_pin(rx_pin), .o_led_level(led_level));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      n_errors++;
    end
  endtask

  task automatic reg_wr(input logic [`IRT_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [`IRT_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // counts samples until the pin leaves the given level
  task automatic run_length(input logic lvl, output int n);
    n = 0;
    while (led_level === lvl) begin
      cycles(1);
      n++;
      if (n > 2000) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic manual_pin();
    reg_wr(`IRT_OFF_POWER, 16'h0003);
    cycles(2);
    check({15'h0000, o_ir_tx_out}, 16'h0001, "manual level");
    check({15'h0000, o_ir_tx_oe_n}, 16'h0000, "manual enable");
  endtask

  task automatic reg_map();
    logic [15:0] d;
    reg_wr(`IRT_OFF_CARRIER, 16'h0102);
    reg_rd(`IRT_OFF_CARRIER, d);
    check(d, 16'h0102, "carrier readback");
    reg_rd(3'h7, d);
    check(d, 16'h0000, "unmapped read");
  endtask

  task automatic carrier_times();
    int hi_n;
    int lo_n;
    reg_wr(`IRT_OFF_MODTIME, 16'hFFFF);
    for (int dv = 0; dv < 2; dv++) begin
      reg_wr(`IRT_OFF_CTRL, 16'h0000);
      reg_wr(`IRT_OFF_CTRL, 16'h0017 | (16'(dv) << 9));
      run_length(1'b1, hi_n);
      run_length(1'b0, lo_n);
      run_length(1'b1, hi_n);
      run_length(1'b0, lo_n);
      check(16'(hi_n), 16'(2 << dv), "carrier high time");
      check(16'(lo_n), 16'(3 << dv), "carrier low time");
    end
  endtask

  task automatic idle_polarity();
    int lows;
    lows = 0;
    reg_wr(`IRT_OFF_POWER, 16'h0002);
    reg_wr(`IRT_OFF_CTRL, 16'h0000);
    reg_wr(`IRT_OFF_CTRL, 16'h001B);
    cycles(5);
    repeat (40) begin
      cycles(1);
      if (led_level !== 1'b1) lows++;
    end
    check(16'(lows), 16'h0000, "idle level with data clear");
  endtask

  // one interval of modulator time 3 holds 3+1 carrier cycles of 2 clocks
  task automatic tx_interval();
    int rises;
    logic prev;
    rises = 0;
    prev = 1'b0;
    reg_wr(`IRT_OFF_CTRL, 16'h0000);
    reg_wr(`IRT_OFF_CARRIER, 16'h0000);
    reg_wr(`IRT_OFF_MODTIME, 16'h0003);
    reg_wr(`IRT_OFF_CTRL, 16'h0003);
    reg_wr(`IRT_OFF_CTRL, 16'h0007);
    fork
      begin
        cycles(8);
        reg_wr(`IRT_OFF_CTRL, 16'h0003);
      end
      repeat (40) begin
        cycles(1);
        if (led_level === 1'b1 && prev === 1'b0) rises++;
        prev = led_level;
      end
    join
    check(16'(rises), 16'h0004, "carrier cycles in one data interval");
  endtask

  // four rising pulses: the first starts the count, the others add one each
  task automatic burst_pulses();
    logic [15:0] d;
    reg_wr(`IRT_OFF_CTRL, 16'h0121);
    repeat (4) begin
      light <= 1'b1;
      cycles(3);
      light <= 1'b0;
      cycles(3);
    end
    reg_rd(`IRT_OFF_VALUE, d);
    check(d, 16'h0003, "burst pulse count");
  endtask

  task automatic rx_capture();
    logic [15:0] d;
    reg_wr(`IRT_OFF_CTRL, 16'h0000);
    reg_wr(`IRT_OFF_STATUS, 16'h0000);
    cycles(4);
    reg_wr(`IRT_OFF_CTRL, 16'h00B1);
    cycles(4);
    light <= 1'b1;
    cycles(10);
    light <= 1'b0;
    cycles(20);
    light <= 1'b1;
    cycles(6);
    reg_rd(`IRT_OFF_MODTIME, d);
    n_checks++;
    if (d < 16'h001D || d > 16'h001F) begin
      $display("wrong value at %0t: captured interval %h", $time, d);
      n_errors++;
    end
    reg_rd(`IRT_OFF_CTRL, d);
    check({15'h0000, d[`IRT_CTRL_DATA]}, 16'h0001, "captured pin level");
    reg_rd(`IRT_OFF_STATUS, d);
    check({15'h0000, d[`IRT_ST_CAP]}, 16'h0001, "capture flag");
  endtask

  task automatic rx_overflow();
    logic [15:0] d;
    int n;
    n = 0;
    reg_wr(`IRT_OFF_CTRL, 16'h0000);
    reg_wr(`IRT_OFF_STATUS, 16'h0000);
    reg_wr(`IRT_OFF_MASK, 16'h0001);
    light <= 1'b1;
    cycles(4);
    check({15'h0000, o_irq}, 16'h0000, "irq before overflow");
    reg_wr(`IRT_OFF_CTRL, 16'h0011);
    cycles(4);
    light <= 1'b0;
    while (o_irq !== 1'b1) begin
      cycles(1);
      n++;
      if (n > 70000) begin
        n_errors++;
        tally_and_finish();
      end
    end
    reg_rd(`IRT_OFF_STATUS, d);
    check({15'h0000, d[`IRT_ST_OVF]}, 16'h0001, "overflow flag");
    cycles(20);
    check({15'h0000, o_irq}, 16'h0001, "overflow flag holds");
    reg_wr(`IRT_OFF_CTRL, 16'h0000);
    reg_wr(`IRT_OFF_STATUS, 16'h0000);
    cycles(2);
    check({15'h0000, o_irq}, 16'h0000, "irq after clear");
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    manual_pin();
    reg_map();
    carrier_times();
    idle_polarity();
    tx_interval();
    rx_capture();
    rx_overflow();
    burst_pulses();
    tally_and_finish();
  end
endmodule
